// ==== logic/pbt_top.sv ====
// Pushbutton toggle debouncer: qualify switch, toggle latched output pair
//
// Operation
// - Qualified closure from cleared drives outputs on
// - Switch release leaves outputs unchanged
// - Next qualified closure inverts outputs again
// - Outside lockout, debounced state changes only after qualification time
// - Sample switch per tick, need consecutive equal samples
// - Counter cleared when sample equals state or differs from previous sample
// - Full count loads sampled level into state
// - Toggle flips only on debounced falling edge
// - Clear rising edge resets toggle; clear held high does not hold it low
// - Supply lockout holds output low, ignores switch
`timescale 1ns/10ps
module pbt_top #(
   parameter int unsigned SAMPLE_CYCLES = pbt_pkg::SAMPLE_CYCLES,
   parameter int unsigned QUAL_SAMPLES = pbt_pkg::QUAL_SAMPLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Pins from the switch side and supply monitor
   input wire pbt_pkg::pbt_pins_t pins,
   // Latched output pair
   output pbt_pkg::pbt_outs_t outs
);
   import pbt_pkg::*;

   // ==========================================================
   // Pin synchronisers
   pbt_pins_t s1_q;
   pbt_pins_t s2_q;
   logic clr_prev_q;
   logic clr_rise;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= '{sw_n: 1'b1, clear: 1'b0, supply_lockout: 1'b1};
         s2_q <= '{sw_n: 1'b1, clear: 1'b0, supply_lockout: 1'b1};
         clr_prev_q <= 1'b0;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         clr_prev_q <= s2_q.clear;
      end
   end

   // Level clear would pin the output low; only its rising edge acts
   assign clr_rise = s2_q.clear & ~clr_prev_q;

   // ==========================================================
   // Sample oscillator: one-cycle tick per sample period
   logic [31:0] div_q;
   logic [31:0] div_d;
   logic tick;

   always_comb begin
      tick = (div_q == SAMPLE_CYCLES - 1);
      div_d = tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= 32'h0000_0000;
      end else begin
         div_q <= div_d;
      end
   end

   // ==========================================================
   // Debounce and toggle
   pbt_state_t st_q;
   pbt_state_t st_d;
   logic smp_q;
   logic smp_d;
   logic deb_q;
   logic deb_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic tog_q;
   logic tog_d;
   pbt_outs_t out_d;

   always_comb begin
      st_d = st_q;
      smp_d = smp_q;
      deb_d = deb_q;
      cnt_d = cnt_q;
      tog_d = tog_q;
      case (st_q)
         PBT_ST_LOCK: begin
            // Lockout: switch ignored, output forced low
            deb_d = DEB_RESET;
            smp_d = DEB_RESET;
            cnt_d = 16'h0000;
            tog_d = TOG_RESET;
            if (!s2_q.supply_lockout) begin
               st_d = PBT_ST_RUN;
            end
         end
         PBT_ST_RUN: begin
            if (s2_q.supply_lockout) begin
               st_d = PBT_ST_LOCK;
               tog_d = TOG_RESET;
            end else begin
               if (tick) begin
                  smp_d = s2_q.sw_n;
                  // A bounce restarts the count: stability must be unbroken
                  if (s2_q.sw_n == deb_q || s2_q.sw_n != smp_q) begin
                     cnt_d = 16'h0000;
                  end else if (cnt_q == 16'(QUAL_SAMPLES - 1)) begin
                     cnt_d = 16'h0000;
                     deb_d = s2_q.sw_n;
                  end else begin
                     cnt_d = cnt_q + 16'h0001;
                  end
               end
               // Closure flips, release does nothing
               if (deb_q && !deb_d) begin
                  tog_d = ~tog_q;
               end
               // Clear wins over a press landing in the same cycle
               if (clr_rise) begin
                  tog_d = TOG_RESET;
               end
            end
         end
         default: begin
            st_d = PBT_ST_LOCK;
         end
      endcase
      out_d.out_on = tog_d;
      out_d.out_on_n = ~tog_d;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= PBT_ST_LOCK;
         smp_q <= DEB_RESET;
         deb_q <= DEB_RESET;
         cnt_q <= 16'h0000;
         tog_q <= TOG_RESET;
         outs <= '{out_on: 1'b0, out_on_n: 1'b1};
      end else begin
         st_q <= st_d;
         smp_q <= smp_d;
         deb_q <= deb_d;
         cnt_q <= cnt_d;
         tog_q <= tog_d;
         outs <= out_d;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence s_press;
      deb_q && !deb_d && !clr_rise && st_q == PBT_ST_RUN
         && !s2_q.supply_lockout;
   endsequence

   property p_press_on;
      s_press and !tog_q |=> outs.out_on && !outs.out_on_n;
   endproperty
   a_press_on: assert property (p_press_on)
      else $error("Closure from cleared did not set output");

   property p_release_hold;
      !deb_q && deb_d && !clr_rise && !s2_q.supply_lockout
         |=> $stable(outs);
   endproperty
   a_release_hold: assert property (p_release_hold)
      else $error("Release changed the output");

   property p_press_off;
      s_press and tog_q |=> !outs.out_on && outs.out_on_n;
   endproperty
   a_press_off: assert property (p_press_off)
      else $error("Second closure did not clear output");

   property p_deb_qual;
      deb_q != $past(deb_q) && st_q == PBT_ST_RUN && $past(st_q) == PBT_ST_RUN
         |-> $past(cnt_q) == 16'(QUAL_SAMPLES - 1);
   endproperty
   a_deb_qual: assert property (p_deb_qual)
      else $error("Debounced state changed before full count");

   property p_count_on_tick;
      !tick && st_q == PBT_ST_RUN && !s2_q.supply_lockout |=> $stable(cnt_q);
   endproperty
   a_count_on_tick: assert property (p_count_on_tick)
      else $error("Counter moved without a sample tick");

   property p_cnt_reset;
      tick && st_q == PBT_ST_RUN && !s2_q.supply_lockout
         && s2_q.sw_n == deb_q |=> cnt_q == 16'h0000;
   endproperty
   a_cnt_reset: assert property (p_cnt_reset)
      else $error("Counter not cleared");

   property p_load;
      tick && st_q == PBT_ST_RUN && !s2_q.supply_lockout
         && s2_q.sw_n != deb_q && s2_q.sw_n == smp_q
         && cnt_q == 16'(QUAL_SAMPLES - 1) |=> deb_q == $past(s2_q.sw_n);
   endproperty
   a_load: assert property (p_load)
      else $error("Full count did not load the sample");

   property p_tog_cause;
      tog_q && !$past(tog_q) |-> $past(deb_q) && !$past(deb_d);
   endproperty
   a_tog_cause: assert property (p_tog_cause)
      else $error("Toggle set without debounced fall");

   property p_clear;
      clr_rise |=> !outs.out_on && outs.out_on_n;
   endproperty
   a_clear: assert property (p_clear)
      else $error("Clear edge did not reset output");

   property p_lockout;
      st_q == PBT_ST_LOCK [*2] |-> !outs.out_on && outs.out_on_n;
   endproperty
   a_lockout: assert property (p_lockout)
      else $error("Output not low under lockout");

   property p_lock_exit;
      st_q == PBT_ST_RUN && $past(st_q) == PBT_ST_LOCK
         |-> deb_q && cnt_q == 16'h0000;
   endproperty
   a_lock_exit: assert property (p_lock_exit)
      else $error("Lockout exit state wrong");

   property p_pair;
      outs.out_on == !outs.out_on_n;
   endproperty
   a_pair: assert property (p_pair)
      else $error("Output pair not complementary");

endmodule // pbt_top

// ==== logic/pbt_pkg.sv ====
// Package: constants and carrier types for the pushbutton toggle debouncer
package pbt_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SAMPLE_PERIOD_US = 1000;
   localparam int unsigned QUAL_TIME_MS = 50;
   localparam int unsigned SAMPLE_CYCLES =
      (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned QUAL_SAMPLES =
      (QUAL_TIME_MS * 1000) / SAMPLE_PERIOD_US;
   // ==========================================================
   // Values after reset
   localparam logic DEB_RESET = 1'b1;
   localparam logic TOG_RESET = 1'b0;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      PBT_ST_LOCK = 2'b00,
      PBT_ST_RUN  = 2'b01
   } pbt_state_t;

   typedef struct packed {
      logic sw_n;
      logic clear;
      logic supply_lockout;
   } pbt_pins_t;

   typedef struct packed {
      logic out_on;
      logic out_on_n;
   } pbt_outs_t;
endpackage

// ==== tb/pbt_switch.sv ====
// Partner model: pushbutton that pulls the switch pin to ground
`timescale 1ns/10ps
module pbt_switch (
   // Clock
   input wire logic sys_clk,
   // Commands from the bench
   input wire logic press,
   input wire logic bounce,
   // Switch pin, pulled up while open
   output wire logic sw_n
);
   logic open_q = 1'b1;
   logic [1:0] ph_q = 2'h0;
   assign sw_n = open_q;
   // Bounce flips the contact every third clock: a toggle every clock
   // would alias with an even sample divider into a settled level
   always @(posedge sys_clk) begin
      if (bounce) begin
         ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
         if (ph_q == 2'h2) begin
            open_q <= ~open_q;
         end
      end else begin
         ph_q <= 2'h0;
         open_q <= ~press;
      end
   end
endmodule // pbt_switch

// ==== tb/pbt_top_bench.sv ====
// Testbench: press, release, bounce, clear and lockout on the debouncer
`timescale 1ns/10ps
module pbt_top_bench;
   import pbt_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic press = 1'b0;
   logic bounce = 1'b0;
   logic clear = 1'b0;
   logic lock = 1'b0;
   logic sw_n;
   pbt_pins_t pins;
   pbt_outs_t outs;
   int err_count = 0;
   int checks_done = 0;
   assign pins = {sw_n, clear, lock};
   // Small counts: 4 clocks per sample, 4 samples to qualify
   pbt_top #(.SAMPLE_CYCLES(4), .QUAL_SAMPLES(4)) i_pbt_top (
      .sys_clk(sys_clk), .arst_n(arst_n), .pins(pins), .outs(outs));
   pbt_switch i_pbt_switch (
      .sys_clk(sys_clk), .press(press), .bounce(bounce), .sw_n(sw_n));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Outputs are looked at mid-cycle, well clear of the launching edge
   task automatic chk(input logic exp);
      @(negedge sys_clk);
      checks_done++;
      if (outs !== {exp, ~exp}) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, outs,
            {exp, ~exp});
      end
   endtask
   task automatic wait_on(input logic exp);
      int i;
      // Outputs move on the rising edge, so poll on the falling one
      for (i = 0; i < 8 && outs.out_on !== exp; i++) @(negedge sys_clk);
      chk(exp);
      if (outs.out_on !== exp) stop_test();
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic push(input logic exp);
      cyc(1);
      press <= 1'b1;
      // Two sync stages plus four full sample periods: no change before
      cyc(19);
      chk(~exp);
      wait_on(exp);
      cyc(1);
      press <= 1'b0;
      cyc(60);
      chk(exp);
   endtask
   task automatic t_press_pair();
      push(1'b1);
      push(1'b0);
   endtask
   task automatic t_bounce();
      cyc(1);
      bounce <= 1'b1;
      cyc(80);
      chk(1'b0);
      cyc(1);
      bounce <= 1'b0;
      cyc(40);
      chk(1'b0);
   endtask
   task automatic t_clear();
      push(1'b1);
      cyc(1);
      clear <= 1'b1;
      cyc(6);
      chk(1'b0);
      push(1'b1);
      cyc(1);
      clear <= 1'b0;
      cyc(6);
      chk(1'b1);
      cyc(1);
      clear <= 1'b1;
      cyc(6);
      chk(1'b0);
      cyc(1);
      clear <= 1'b0;
   endtask
   task automatic t_lockout();
      push(1'b1);
      cyc(1);
      lock <= 1'b1;
      cyc(6);
      chk(1'b0);
      cyc(1);
      press <= 1'b1;
      cyc(60);
      chk(1'b0);
      cyc(1);
      press <= 1'b0;
      cyc(60);
      lock <= 1'b0;
      cyc(80);
      chk(1'b0);
      push(1'b1);
   endtask
   initial begin
      cyc(12);
      arst_n <= 1'b1;
      cyc(8);
      chk(1'b0);
      t_press_pair();
      t_bounce();
      t_clear();
      t_lockout();
      stop_test();
   end
endmodule // pbt_top_bench
